// [rtl/ddc_pkg.sv]
package ddc_pkg;

  localparam int SMP_W = 16;
  localparam int OUT_W = 15;
  localparam int REAL_W = 12;
  localparam int ACC_W = 48;
  localparam int CNT_W = 6;
  localparam int NUM_STG = 5;
  localparam int TAB_W = 28;

  // half-set length (center excluded) and output shift of each half-band stage
  localparam int HALF_LEN [NUM_STG] = '{3, 3, 5, 7, 27};
  localparam int SCALE_SH [NUM_STG] = '{5, 11, 14, 17, 19};

  // half set followed by the center tap at index HALF_LEN
  localparam int COEF_TAB [NUM_STG][TAB_W] = '{
    '{0: -1, 1: 0, 2: 9, 3: 16, default: 0},
    '{0: -65, 1: 0, 2: 577, 3: 1024, default: 0},
    '{0: 109, 1: 0, 2: -837, 3: 0, 4: 4824, 5: 8192, default: 0},
    '{0: -327, 1: 0, 2: 2231, 3: 0, 4: -8881, 5: 0, 6: 39742, 7: 65536, default: 0},
    '{-37, 0, 118, 0, -291, 0, 612, 0, -1159, 0, 2031, 0, -3356, 0,
      5308, 0, -8140, 0, 12284, 0, -18628, 0, 29455, 0, -53191, 0, 166059, 262144}
  };

  typedef enum logic [2:0] {
    DDC_BYPASS = 3'h0,
    DDC_DEC4 = 3'h1,
    DDC_DEC8 = 3'h2,
    DDC_DEC16 = 3'h3,
    DDC_DEC32 = 3'h4
  } ddc_mode_t;

  typedef struct packed {
    logic [SMP_W-1:0] i;
    logic [SMP_W-1:0] q;
  } ddc_iq_t;

  typedef struct packed {
    logic vld;
    ddc_iq_t iq;
  } ddc_smp_t;

  // mirrored coefficient of full tap k
  function automatic int hbCoef(int stg, int k);
    int h;
    int j;
    h = HALF_LEN[stg];
    j = (k <= h) ? k : 2 * h - k;
    return COEF_TAB[stg][j];
  endfunction

  function automatic int firstStg(ddc_mode_t m);
    return NUM_STG - 1 - int'(m);
  endfunction

  function automatic logic stgUsed(ddc_mode_t m, int s);
    return (m != DDC_BYPASS) && (s >= firstStg(m));
  endfunction

  function automatic logic [CNT_W-1:0] decFactor(ddc_mode_t m);
    logic [CNT_W-1:0] f;
    unique case (m)
      DDC_DEC4: f = 6'h04;
      DDC_DEC8: f = 6'h08;
      DDC_DEC16: f = 6'h10;
      DDC_DEC32: f = 6'h20;
      default: f = 6'h01;
    endcase
    return f;
  endfunction

endpackage

// [rtl/ddc_decim_chain.sv]
`timescale 1ns/1ns

module ddc_halfband_stage import ddc_pkg::*; #(
  parameter int STG = 0,
  parameter int OW = SMP_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire ddc_smp_t inSmp,
  output ddc_smp_t outSmp
);

  localparam int NT = 2 * HALF_LEN[STG] + 1;
  localparam int SH = SCALE_SH[STG];
  localparam logic signed [SMP_W-1:0] OMAX = SMP_W'((1 <<< (OW - 1)) - 1);
  localparam logic signed [SMP_W-1:0] OMIN = -OMAX - SMP_W'(1);

  if (OW > SMP_W || OW < 2 || STG >= NUM_STG) begin : g_chk
    $error("stage width or index out of range");
  end

  typedef struct packed {
    logic [NT-1:0][SMP_W-1:0] dI;
    logic [NT-1:0][SMP_W-1:0] dQ;
    logic phase;
    ddc_smp_t o;
  } ddc_stg_t;

  ddc_stg_t st_q;
  ddc_stg_t st_d;

  function automatic logic [SMP_W-1:0] ddcFilt(logic [NT-1:0][SMP_W-1:0] d);
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] lim;
    acc = '0;
    for (int k = 0; k < NT; k++) begin
      acc += ACC_W'(hbCoef(STG, k)) * ACC_W'($signed(d[k]));
    end
    acc = (acc + (ACC_W'(1) <<< (SH - 1))) >>> SH;
    lim = ACC_W'(OMAX);
    if (acc > lim) begin
      acc = lim;
    end else if (acc < -lim - ACC_W'(1)) begin
      acc = -lim - ACC_W'(1);
    end
    return acc[SMP_W-1:0];
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.o.vld = 1'b0;
    if (inSmp.vld) begin
      st_d.dI = {st_q.dI[NT-2:0], inSmp.iq.i};
      st_d.dQ = {st_q.dQ[NT-2:0], inSmp.iq.q};
      st_d.phase = ~st_q.phase;
      if (st_q.phase) begin
        st_d.o.vld = 1'b1;
        st_d.o.iq.i = ddcFilt(st_d.dI);
        st_d.o.iq.q = ddcFilt(st_d.dQ);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign outSmp = st_q.o;

  stage_half_a: assert property (
    @(posedge mclk) disable iff (rst)
    outSmp.vld |-> !st_q.phase && $past(inSmp.vld) && $past(st_q.phase))
    else $error("stage output not on second input");

  stage_gap_a: assert property (
    @(posedge mclk) disable iff (rst)
    outSmp.vld |=> !outSmp.vld)
    else $error("stage outputs back to back");

  stage_sat_a: assert property (
    @(posedge mclk) disable iff (rst)
    outSmp.vld |-> $signed(outSmp.iq.i) <= OMAX && $signed(outSmp.iq.i) >= OMIN
      && $signed(outSmp.iq.q) <= OMAX && $signed(outSmp.iq.q) >= OMIN)
    else $error("stage output beyond its width");

  stage_idle_a: assert property (
    @(posedge mclk) disable iff (rst)
    !inSmp.vld |=> !outSmp.vld)
    else $error("stage output without input");

endmodule

// How it works
// - modes: bypass, or decimate by 4, 8, 16, 32.
// - bypass passes 12-bit real samples each input, unfiltered, undecimated.
// - every stage filters i and q together as one complex pair.
// - decimating output carries 15-bit i and 15-bit q.
// - each stage is a linear-phase fir.
// - output rate is input rate divided by the chosen factor.
// - by 4 uses stages four, final; by 8 adds stage three first.
// - by 16 starts at stage two; by 32 uses all five.
// - each stage halves the rate and shifts by its power of two.
// - tap sets are mirrored around one center tap.
// - first stage: -1, 0, 9, center 16, shift 5.
// - second stage: -65, 0, 577, center 1024, shift 11.
// - third stage: 109, 0, -837, 0, 4824, center 8192, shift 14.
// - fourth stage: -327 .. 39742, center 65536, shift 17.
// - final stage: -37, 0, 118 .. 166059, center 262144, shift 19.
// - composite response rejects aliases over 90 dB, ripple 0.001 dB.
// - pass band is 0.8 output rate, or half clock in bypass.
// - setting comes from the link mode select input only.
// - 16-bit words in decimating modes: 15 data bits, overrange flag in bit 0.
module ddc_decim_chain import ddc_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire ddc_mode_t linkModeSelect,
  input wire ddc_smp_t mixSmp,
  input wire logic [REAL_W-1:0] realIn,
  input wire logic overrangeFlagFirst,
  input wire logic overrangeFlagSecond,
  output logic [SMP_W-1:0] outWordI,
  output logic [SMP_W-1:0] outWordQ,
  output logic outVld
);

  typedef struct packed {
    logic [SMP_W-1:0] wI;
    logic [SMP_W-1:0] wQ;
    logic vld;
    logic ovr0;
    logic ovr1;
    logic [CNT_W-1:0] inCnt;
    logic [1:0] seenCnt;
    ddc_mode_t modeQ;
  } ddc_chn_t;

  ddc_chn_t c_q;
  ddc_chn_t c_d;
  ddc_smp_t stIn [NUM_STG];
  ddc_smp_t stOut [NUM_STG];
  ddc_smp_t fin;
  logic byp;

  assign byp = (linkModeSelect == DDC_BYPASS);
  assign fin = stOut[NUM_STG-1];

  for (genvar s = 0; s < NUM_STG; s++) begin : g_stg
    ddc_smp_t src;
    if (s == 0) begin : g_head
      assign src = mixSmp;
    end else begin : g_tail
      assign src = (s == firstStg(linkModeSelect)) ? mixSmp : stOut[s-1];
    end
    assign stIn[s] = '{vld: src.vld && stgUsed(linkModeSelect, s), iq: src.iq};
    ddc_halfband_stage #(
      .STG(s),
      .OW(s == NUM_STG - 1 ? OUT_W : SMP_W)
    ) u_stg (
      .mclk(mclk),
      .rst(rst),
      .inSmp(stIn[s]),
      .outSmp(stOut[s])
    );
  end

  // flags gather over the whole decimation window; a new one beats the clear
  always_comb begin
    c_d = c_q;
    c_d.vld = 1'b0;
    c_d.modeQ = linkModeSelect;
    c_d.ovr0 = c_q.ovr0 | overrangeFlagFirst;
    c_d.ovr1 = c_q.ovr1 | overrangeFlagSecond;
    c_d.inCnt = c_q.inCnt + CNT_W'(mixSmp.vld);
    if (linkModeSelect != c_q.modeQ) begin
      c_d.seenCnt = 2'h0;
    end
    if (byp) begin
      if (mixSmp.vld) begin
        c_d.vld = 1'b1;
        c_d.wI = {realIn, 4'h0};
        c_d.wQ = '0;
      end
    end else if (fin.vld) begin
      c_d.vld = 1'b1;
      c_d.wI = {fin.iq.i[OUT_W-1:0], c_q.ovr0 | overrangeFlagFirst};
      c_d.wQ = {fin.iq.q[OUT_W-1:0], c_q.ovr1 | overrangeFlagSecond};
      c_d.ovr0 = overrangeFlagFirst;
      c_d.ovr1 = overrangeFlagSecond;
      c_d.inCnt = CNT_W'(mixSmp.vld);
      if (linkModeSelect == c_q.modeQ && c_q.seenCnt != 2'h3) begin
        c_d.seenCnt = c_q.seenCnt + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign outWordI = c_q.wI;
  assign outWordQ = c_q.wQ;
  assign outVld = c_q.vld;

  byp_pass_a: assert property (
    @(posedge mclk) disable iff (rst)
    byp && mixSmp.vld |=> outVld && outWordI[SMP_W-1:4] == $past(realIn) && outWordQ == '0)
    else $error("bypass sample not passed");

  out_rate_a: assert property (
    @(posedge mclk) disable iff (rst)
    fin.vld && !byp && c_q.seenCnt == 2'h3 && linkModeSelect == c_q.modeQ
      |-> c_q.inCnt == decFactor(linkModeSelect))
    else $error("output spacing differs from factor");

  out_flagi_a: assert property (
    @(posedge mclk) disable iff (rst)
    fin.vld && !byp && overrangeFlagFirst |=> outVld && outWordI[0])
    else $error("first overrange flag lost");

  out_flagq_a: assert property (
    @(posedge mclk) disable iff (rst)
    fin.vld && !byp && !c_q.ovr1 && !overrangeFlagSecond |=> outVld && !outWordQ[0])
    else $error("second overrange flag spurious");

  out_data_a: assert property (
    @(posedge mclk) disable iff (rst)
    fin.vld && !byp |=> outWordI[SMP_W-1:1] == $past(fin.iq.i[OUT_W-1:0])
      && outWordQ[SMP_W-1:1] == $past(fin.iq.q[OUT_W-1:0]))
    else $error("output data misplaced");

  stg_first_a: assert property (
    @(posedge mclk) disable iff (rst)
    stOut[0].vld |-> $past(linkModeSelect) == DDC_DEC32)
    else $error("first stage ran outside by 32");

  stg_third_a: assert property (
    @(posedge mclk) disable iff (rst)
    stOut[2].vld |-> $past(linkModeSelect) inside {DDC_DEC8, DDC_DEC16, DDC_DEC32})
    else $error("third stage ran in by 4 or bypass");

  stg_second_a: assert property (
    @(posedge mclk) disable iff (rst)
    stOut[1].vld |-> $past(linkModeSelect) inside {DDC_DEC16, DDC_DEC32})
    else $error("second stage ran below by 16");

  stg_fourth_a: assert property (
    @(posedge mclk) disable iff (rst)
    stOut[3].vld |-> $past(linkModeSelect) != DDC_BYPASS)
    else $error("fourth stage ran in bypass");

  stg_final_a: assert property (
    @(posedge mclk) disable iff (rst)
    fin.vld |-> $past(linkModeSelect) != DDC_BYPASS)
    else $error("final stage ran in bypass");

  out_idle_a: assert property (
    @(posedge mclk) disable iff (rst)
    !byp && !fin.vld |=> !outVld)
    else $error("decimated output without final sample");

  byp_idle_a: assert property (
    @(posedge mclk) disable iff (rst)
    byp && !mixSmp.vld |=> !outVld)
    else $error("bypass output without input");

  flagq_set_a: assert property (
    @(posedge mclk) disable iff (rst)
    fin.vld && !byp && overrangeFlagSecond |=> outVld && outWordQ[0])
    else $error("second overrange flag lost");

  flagi_clr_a: assert property (
    @(posedge mclk) disable iff (rst)
    fin.vld && !byp && !c_q.ovr0 && !overrangeFlagFirst |=> outVld && !outWordI[0])
    else $error("first overrange flag spurious");

  out_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    !outVld |-> $stable(outWordI) && $stable(outWordQ))
    else $error("output words moved without strobe");

endmodule

// [bench/ddc_mixer_model.sv]
`timescale 1ns/1ns
module ddc_mixer_model import ddc_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic slow,
  input wire ddc_iq_t iqVal,
  input wire logic [REAL_W-1:0] realVal,
  output ddc_smp_t mixSmp,
  output logic [REAL_W-1:0] realIn
);
  logic phase_q;
  logic go;
  assign go = run && (!slow || phase_q);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_q <= 1'b0;
      mixSmp <= '0;
      realIn <= '0;
    end else begin
      phase_q <= ~phase_q;
      mixSmp.vld <= go;
      // idle data flips so a stale sample cannot pass for a new one
      mixSmp.iq <= go ? iqVal : ~mixSmp.iq;
      realIn <= go ? realVal : ~realIn;
    end
  end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top import ddc_pkg::*; ();
  logic mclk, rst, run, slow, flagFirst, flagSecond, outVld;
  ddc_mode_t mode;
  ddc_iq_t iqVal;
  ddc_smp_t mixSmp;
  logic [REAL_W-1:0] realVal, realIn;
  logic [SMP_W-1:0] outWordI, outWordQ;
  int mismatches, checked;

  ddc_mixer_model ddc_mixer_model_i (.mclk(mclk), .rst(rst), .run(run), .slow(slow),
    .iqVal(iqVal), .realVal(realVal), .mixSmp(mixSmp), .realIn(realIn));
  ddc_decim_chain ddc_decim_chain_i (.mclk(mclk), .rst(rst), .linkModeSelect(mode),
    .mixSmp(mixSmp), .realIn(realIn), .overrangeFlagFirst(flagFirst),
    .overrangeFlagSecond(flagSecond), .outWordI(outWordI), .outWordQ(outWordQ),
    .outVld(outVld));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitVld(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (outVld !== 1'b1 && n < 5000);
    if (outVld !== 1'b1) begin
      mismatches++;
      finish_test();
    end
  endtask

  // steady dc response: tap sum per stage, round, saturate, flag in bit 0
  function automatic logic [15:0] dcExp(int x, int m, logic f);
    longint y, s, lim;
    y = x;
    for (int st = 4 - m; st < NUM_STG; st++) begin
      s = COEF_TAB[st][HALF_LEN[st]];
      for (int k = 0; k < HALF_LEN[st]; k++) s += 2 * COEF_TAB[st][k];
      y = (y * s + (longint'(1) <<< (SCALE_SH[st] - 1))) >>> SCALE_SH[st];
      lim = (st == NUM_STG - 1) ? 16383 : 32767;
      if (y > lim) y = lim;
      if (y < -lim - 1) y = -lim - 1;
    end
    return {y[14:0], f};
  endfunction

  task automatic bypass_test();
    mode <= DDC_BYPASS;
    realVal <= 12'hA5C;
    run <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    cmp({15'h0000, outVld}, 16'h0001);
    cmp(outWordI, 16'hA5C0);
    cmp(outWordQ, 16'h0000);
    @(posedge mclk);
    run <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    cmp({15'h0000, outVld}, 16'h0000);
  endtask

  task automatic decim(input int m, input logic sl);
    int n, f, xi, xq;
    logic od;
    od = (m % 2) == 1;
    f = (sl ? 2 : 1) * (4 <<< (m - 1));
    xi = od ? 8000 : -9000;
    xq = od ? -20000 : 20000;
    @(posedge mclk);
    mode <= ddc_mode_t'(m);
    slow <= sl;
    run <= 1'b1;
    iqVal <= {16'(xi), 16'(xq)};
    flagFirst <= od;
    flagSecond <= ~od;
    // long enough for the final stage delay line to hold only new data
    repeat (70 * f) @(posedge mclk);
    waitVld(n);
    waitVld(n);
    cmp(16'(n), 16'(f));
    cmp(outWordI, dcExp(xi, m, od));
    cmp(outWordQ, dcExp(xq, m, ~od));
  endtask

  task automatic reset_test();
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    #1;
    cmp({15'h0000, outVld}, 16'h0000);
    cmp(outWordI, 16'h0000);
    cmp(outWordQ, 16'h0000);
    @(posedge mclk);
    rst <= 1'b0;
    decim(1, 1'b0);
  endtask

  initial begin
    mismatches = 0;
    checked = 0;
    rst = 1'b1;
    run = 1'b0;
    slow = 1'b0;
    flagFirst = 1'b0;
    flagSecond = 1'b0;
    mode = DDC_BYPASS;
    iqVal = '0;
    realVal = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    bypass_test();
    for (int m = 1; m < 5; m++) decim(m, 1'b0);
    decim(1, 1'b1);
    reset_test();
    finish_test();
  end
endmodule
